// File: sfpi_host.sv
// host controller model: select, serial clock, lanes
`timescale 1ns/1ps
`default_nettype none
module sfpi_host (
    // timing reference and pins
    input wire logic clk,
    output logic sel_n,
    output logic sck,
    output logic [3:0] dq
);
    initial begin
        sel_n = 1'b1;
        sck = 1'b0;
        dq = 4'hf;
    end
    task automatic sel(input logic v);
        @(negedge clk);
        sel_n = v;
    endtask : sel
    task automatic clocks(input int n);
        repeat (n) begin
            #24 sck = 1'b1;
            #24 sck = 1'b0;
        end
    endtask : clocks
endmodule : sfpi_host
`default_nettype wire

// File: sfpi_map.svh
// register-free constants for the serial flash pin front end
`ifndef SFPI_MAP_SVH
`define SFPI_MAP_SVH
`define SFPI_CFG_PIN_DIS_BIT 4
`define SFPI_SR_WR_DIS_BIT 7
`define SFPI_SR_RESET 8'h00
`define SFPI_LANE_WIDTH 4
`define SFPI_PIN_IDLE 8'hfa
`endif

// File: sfpi_pins.sv
// pin front end of a multi-lane serial flash: select, clock, hold, reset
`timescale 1ns/1ps
`default_nettype none
`include "sfpi_map.svh"

// Overview of operation
// - select high enters standby unless busy
// - deselected ignores inputs, outputs float
// - dedicated reset pin works while deselected
// - select low enters active mode
// - command bits sampled on rising clock
// - single rate: sample rise, launch fall
// - double rate: sample and drive both
// - reset pin low resets, floats outputs
// - config bit four disables reset pin
// - shared reset inactive in quad protocol
// - hold pauses, floats outputs, ignores inputs
// - config bit four disables hold
// - shared hold off in quad or double
// - write-disable and protect low block writes
// - protect pin is lane two, ignored in quad
// - single: lane0 in, lane1 out
// - dual: lanes one, zero bidirectional
// - quad: all four lanes bidirectional
// - status bit seven is write-disable
module sfpi_pins
    import sfpi_pkg::*;
#(
    parameter bit SHARED_RESET = 1'b1,
    parameter bit SHARED_HOLD = 1'b0,
    parameter bit DEDICATED_RESET = 1'b0
) (
    // clock and reset
    input wire logic I_CLK,
    input wire logic I_NRST,
    // link pins
    input wire logic I_SEL_N,
    input wire logic I_SCK,
    input wire logic I_RESET_N,
    input wire logic [3:0] I_DQ,
    output logic [3:0] O_DQ,
    output logic [3:0] O_DQ_OE,
    // configuration from the core
    input wire logic I_NVCFG_PIN_DIS_N,
    input wire logic I_EVCFG_PIN_DIS_N,
    input wire logic [2:0] I_PROTO,
    input wire logic [2:0] I_LANES,
    input wire logic I_DOUBLE_RATE,
    input wire logic I_BUSY,
    input wire logic I_SR_WRITE_REQ,
    input wire logic [7:0] I_SR_WDATA,
    // core data path
    input wire logic I_TX_EN,
    input wire logic [3:0] I_TX_DATA,
    output logic O_TX_TAKE,
    output logic [3:0] O_RX_DATA,
    output logic O_RX_VALID,
    output logic O_RX_ON_RISE,
    // status to the core
    output logic O_ACTIVE,
    output logic O_STANDBY,
    output logic O_HOLD,
    output logic O_PIN_RESET,
    output logic O_CMD_START,
    output logic O_CMD_END,
    output logic O_SR_WRITE_DONE,
    output logic O_SR_WRITE_BLOCKED,
    output logic [7:0] O_SR
);
    // two-flop synchronisers for every pin
    logic [7:0] pin_meta_q;
    logic [7:0] pin_sync_q;
    logic [7:0] pin_prev_q;
    wire [7:0] pin_raw = {I_DQ, I_RESET_N, I_SCK, I_SEL_N, 1'b0};

    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            // idle pin levels, so no false select or clock edge after reset
            pin_meta_q <= `SFPI_PIN_IDLE;
            pin_sync_q <= `SFPI_PIN_IDLE;
            pin_prev_q <= `SFPI_PIN_IDLE;
        end else begin
            pin_meta_q <= pin_raw;
            pin_sync_q <= pin_meta_q;
            pin_prev_q <= pin_sync_q;
        end
    end

    wire sel_n = pin_sync_q[1];
    wire sck = pin_sync_q[2];
    wire rst_pin_n = pin_sync_q[3];
    wire [3:0] dq_in = pin_sync_q[7:4];
    wire sel_fall = pin_prev_q[1] & ~sel_n;
    wire sel_rise = ~pin_prev_q[1] & sel_n;
    wire sck_rise = sck & ~pin_prev_q[2];
    wire sck_fall = ~sck & pin_prev_q[2];

    // pin function enables
    wire cfg_dis = ~I_NVCFG_PIN_DIS_N | ~I_EVCFG_PIN_DIS_N;
    wire quad_proto = I_PROTO == SFPI_PROTO_QUAD;
    wire rst_shared_on = SHARED_RESET & ~quad_proto;
    wire hold_shared_on = SHARED_HOLD & ~quad_proto & ~I_DOUBLE_RATE;
    wire rst_pin_low = DEDICATED_RESET ? ~rst_pin_n : ~dq_in[3];
    // dedicated pin sampled regardless of select
    wire rst_act = ~cfg_dis & rst_pin_low
                   & (DEDICATED_RESET | (rst_shared_on & ~sel_n));
    wire hold_act = ~cfg_dis & hold_shared_on & ~dq_in[3] & ~sel_n;

    // lanes that carry data both ways for a lane code
    function automatic logic [3:0] sfpi_lane_mask(input logic [2:0] code);
        logic [3:0] m;
        m = 4'h0;
        if (code == SFPI_LANES_QUAD) begin
            m = 4'hf;
        end else if (code == SFPI_LANES_DUAL) begin
            m = 4'h3;
        end
        return m;
    endfunction : sfpi_lane_mask

    // lane usage: single, dual, quad
    wire [3:0] lane_bidir = sfpi_lane_mask(I_LANES);

    sfpi_state_t state_q;
    sfpi_state_t state_d;
    logic armed_q;

    always_comb begin
        state_d = state_q;
        case (state_q)
            SFPI_ST_STANDBY: begin
                if (rst_act) begin
                    state_d = SFPI_ST_RESET;
                end else if (sel_fall) begin
                    state_d = SFPI_ST_ACTIVE;
                end
            end
            SFPI_ST_ACTIVE: begin
                if (rst_act) begin
                    state_d = SFPI_ST_RESET;
                end else if (sel_n) begin
                    state_d = SFPI_ST_STANDBY;
                end else if (hold_act) begin
                    state_d = SFPI_ST_HOLD;
                end
            end
            SFPI_ST_HOLD: begin
                if (rst_act) begin
                    state_d = SFPI_ST_RESET;
                end else if (sel_n) begin
                    state_d = SFPI_ST_STANDBY;
                end else if (!hold_act) begin
                    state_d = SFPI_ST_ACTIVE;
                end
            end
            SFPI_ST_RESET: begin
                if (!rst_act) begin
                    state_d = SFPI_ST_STANDBY;
                end
            end
            default: begin
                state_d = SFPI_ST_STANDBY;
            end
        endcase
    end

    // commands only after a select fall seen since reset
    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            state_q <= SFPI_ST_STANDBY;
            armed_q <= 1'b0;
        end else begin
            state_q <= state_d;
            if (state_q == SFPI_ST_RESET) begin
                armed_q <= 1'b0;
            end else if (sel_fall) begin
                armed_q <= 1'b1;
            end
        end
    end

    wire active = (state_q == SFPI_ST_ACTIVE) & armed_q & ~sel_n;
    // rise always samples; fall samples only at double rate
    wire sample_ev = active & (sck_rise | (I_DOUBLE_RATE & sck_fall));
    wire launch_ev = active & I_TX_EN
                     & (sck_fall | (I_DOUBLE_RATE & sck_rise));
    wire [3:0] rx_mask = (I_LANES == SFPI_LANES_SINGLE) ? 4'h1 : lane_bidir;
    wire [3:0] tx_mask = (I_LANES == SFPI_LANES_SINGLE) ? 4'h2 : lane_bidir;

    logic [3:0] rx_q;
    logic rx_valid_q;
    logic rx_rise_q;
    logic [3:0] tx_q;
    logic tx_oe_q;

    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            rx_q <= 4'h0;
            rx_valid_q <= 1'b0;
            rx_rise_q <= 1'b0;
        end else begin
            rx_valid_q <= sample_ev & ~I_TX_EN;
            if (sample_ev) begin
                rx_q <= dq_in & rx_mask;
                rx_rise_q <= sck_rise;
            end
        end
    end

    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            tx_q <= 4'h0;
            tx_oe_q <= 1'b0;
        end else begin
            if (!active || !I_TX_EN) begin
                tx_oe_q <= 1'b0;
            end else if (launch_ev) begin
                tx_oe_q <= 1'b1;
            end
            if (launch_ev) begin
                tx_q <= (I_LANES == SFPI_LANES_SINGLE) ?
                        {2'b00, I_TX_DATA[0], 1'b0} : I_TX_DATA & tx_mask;
            end
        end
    end

    // drive stops at once when the device leaves the active state
    assign O_DQ = tx_q;
    assign O_DQ_OE = (tx_oe_q & active) ? tx_mask : 4'h0;
    assign O_TX_TAKE = launch_ev;
    assign O_RX_DATA = rx_q;
    assign O_RX_VALID = rx_valid_q;
    assign O_RX_ON_RISE = rx_rise_q;

    // status register with hardware write protection
    logic [7:0] sr_q;
    logic sr_done_q;
    logic sr_blk_q;
    logic sr_pend_q;
    wire wp_pin_n = dq_in[2];
    wire wp_is_data = lane_bidir[2];
    wire sr_locked = sr_q[`SFPI_SR_WR_DIS_BIT] & ~wp_pin_n
                     & ~wp_is_data;
    wire cmd_end = sel_rise & armed_q;

    always_ff @(posedge I_CLK or negedge I_NRST) begin
        if (!I_NRST) begin
            sr_q <= `SFPI_SR_RESET;
            sr_done_q <= 1'b0;
            sr_blk_q <= 1'b0;
            sr_pend_q <= 1'b0;
        end else begin
            sr_done_q <= 1'b0;
            sr_blk_q <= 1'b0;
            if (state_q == SFPI_ST_RESET) begin
                sr_pend_q <= 1'b0;
            end else if (I_SR_WRITE_REQ && active) begin
                sr_pend_q <= 1'b1;
            end else if (cmd_end && sr_pend_q) begin
                sr_pend_q <= 1'b0;
                if (sr_locked) begin
                    sr_blk_q <= 1'b1;
                end else begin
                    sr_q <= I_SR_WDATA;
                    sr_done_q <= 1'b1;
                end
            end
        end
    end

    // busy keeps the device out of standby while selected is high
    assign O_ACTIVE = active;
    assign O_STANDBY = (state_q == SFPI_ST_STANDBY) & ~I_BUSY;
    assign O_HOLD = state_q == SFPI_ST_HOLD;
    assign O_PIN_RESET = state_q == SFPI_ST_RESET;
    assign O_CMD_START = sel_fall & (state_q == SFPI_ST_STANDBY) & ~rst_act;
    assign O_CMD_END = cmd_end;
    assign O_SR_WRITE_DONE = sr_done_q;
    assign O_SR_WRITE_BLOCKED = sr_blk_q;
    assign O_SR = sr_q;
endmodule : sfpi_pins
`default_nettype wire

// File: sfpi_pins_checker.sv
// port assertions for the serial flash pin front end
`timescale 1ns/1ps
`default_nettype none
module sfpi_pins_checker
    import sfpi_pkg::*;
(
    // pins and controls
    input wire logic I_CLK,
    input wire logic I_NRST,
    input wire logic I_SEL_N,
    input wire logic I_SCK,
    input wire logic [3:0] I_DQ,
    input wire logic I_NVCFG_PIN_DIS_N,
    input wire logic I_EVCFG_PIN_DIS_N,
    input wire logic [2:0] I_PROTO,
    input wire logic I_DOUBLE_RATE,
    input wire logic I_BUSY,
    input wire logic I_TX_EN,
    // watched outputs
    input wire logic [3:0] O_DQ_OE,
    input wire logic O_RX_VALID,
    input wire logic O_RX_ON_RISE,
    input wire logic O_ACTIVE,
    input wire logic O_STANDBY,
    input wire logic O_PIN_RESET,
    input wire logic O_CMD_START
);
    default clocking @(posedge I_CLK);
    endclocking
    default disable iff (!I_NRST);
    wire logic rx_ok = O_ACTIVE && !I_TX_EN;
    wire logic en = I_NVCFG_PIN_DIS_N && I_EVCFG_PIN_DIS_N
        && I_PROTO != SFPI_PROTO_QUAD;
    property p_float; !O_ACTIVE [*2] |-> O_DQ_OE == 4'h0; endproperty
    a_float: assert property (p_float) else $error("lanes driven");
    property p_busy; I_BUSY && I_SEL_N |-> !O_STANDBY; endproperty
    a_busy: assert property (p_busy) else $error("standby while busy");
    property p_start; $fell(I_SEL_N) && O_STANDBY && !O_PIN_RESET
        ##1 !I_SEL_N [*2] |-> O_CMD_START; endproperty
    a_start: assert property (p_start) else $error("no start");
    property p_rise; $rose(I_SCK) && rx_ok
        |-> ##[3:5] O_RX_VALID && O_RX_ON_RISE; endproperty
    a_rise: assert property (p_rise) else $error("rise lost");
    property p_fall; $fell(I_SCK) && rx_ok && !I_DOUBLE_RATE
        |-> ##3 !O_RX_VALID [*3]; endproperty
    a_fall: assert property (p_fall) else $error("fall sampled");
    property p_ddr; $fell(I_SCK) && rx_ok && I_DOUBLE_RATE
        |-> ##[3:5] O_RX_VALID && !O_RX_ON_RISE; endproperty
    a_ddr: assert property (p_ddr) else $error("fall lost");
    property p_rst; (!I_SEL_N && !I_DQ[3] && en) [*8] |-> O_PIN_RESET;
    endproperty
    a_rst: assert property (p_rst) else $error("no pin reset");
    property p_dis; !en [*8] |-> !O_PIN_RESET; endproperty
    a_dis: assert property (p_dis) else $error("reset not off");
endmodule : sfpi_pins_checker
bind sfpi_pins sfpi_pins_checker i_chk (.*);
`default_nettype wire

// File: sfpi_pkg.sv
// types for the serial flash pin front end
`include "sfpi_map.svh"
package sfpi_pkg;
    typedef enum logic [2:0] {
        SFPI_LANES_SINGLE = 3'b001,
        SFPI_LANES_DUAL = 3'b010,
        SFPI_LANES_QUAD = 3'b100
    } sfpi_lanes_t;
    typedef enum logic [2:0] {
        SFPI_PROTO_EXTENDED = 3'b001,
        SFPI_PROTO_DUAL = 3'b010,
        SFPI_PROTO_QUAD = 3'b100
    } sfpi_proto_t;
    typedef enum logic [3:0] {
        SFPI_ST_STANDBY = 4'b0001,
        SFPI_ST_ACTIVE = 4'b0010,
        SFPI_ST_HOLD = 4'b0100,
        SFPI_ST_RESET = 4'b1000
    } sfpi_state_t;
endpackage : sfpi_pkg

// File: tb.sv
// bench for the serial flash pin front end
`timescale 1ns/1ps
`default_nettype none
module tb;
    import sfpi_pkg::*;
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic nv = 1'b1;
    logic ev = 1'b1;
    logic [3:0] txd = 4'h5;
    logic [3:0] dq_seen;
    logic take, act, hold, cst, cend, sdone, sblk, rise;
    int n_take = 0;
    int n_cst = 0;
    int n_cend = 0;
    int n_done = 0;
    int n_blk = 0;
    int n_rise = 0;
    logic dr = 1'b0;
    logic busy = 1'b0;
    logic req = 1'b0;
    logic txen = 1'b0;
    logic [2:0] proto = 3'h1;
    logic [2:0] lanes = 3'h1;
    logic [7:0] wdata = 8'h00;
    logic [3:0] o_dq, oe, rxd, last_rx, oe_seen;
    logic [7:0] sr;
    logic sel_n, sck, rx_v, standby, pin_rst;
    wire logic [3:0] hdq;
    wire logic [3:0] dq = (oe & o_dq) | (~oe & hdq);
    int failures = 0;
    int n_checks = 0;
    int n_rx = 0;
    int cyc = 0;
    always #2.5 clk = ~clk;
    sfpi_host i_host (.clk(clk), .sel_n(sel_n), .sck(sck), .dq(hdq));
    sfpi_pins i_dut (.I_CLK(clk), .I_NRST(nrst), .I_SEL_N(sel_n),
        .I_SCK(sck), .I_RESET_N(1'b1), .I_DQ(dq), .O_DQ(o_dq), .O_DQ_OE(oe),
        .I_NVCFG_PIN_DIS_N(nv), .I_EVCFG_PIN_DIS_N(ev), .I_PROTO(proto),
        .I_LANES(lanes), .I_DOUBLE_RATE(dr), .I_BUSY(busy),
        .I_SR_WRITE_REQ(req), .I_SR_WDATA(wdata), .I_TX_EN(txen),
        .I_TX_DATA(txd), .O_TX_TAKE(take), .O_RX_DATA(rxd),
        .O_RX_VALID(rx_v), .O_RX_ON_RISE(rise), .O_ACTIVE(act),
        .O_STANDBY(standby), .O_HOLD(hold), .O_PIN_RESET(pin_rst),
        .O_CMD_START(cst), .O_CMD_END(cend), .O_SR_WRITE_DONE(sdone),
        .O_SR_WRITE_BLOCKED(sblk), .O_SR(sr));
    task automatic stop_test();
        $display("checks %0d failures %0d", n_checks, failures);
        if (failures == 0 && n_checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : stop_test
    always @(posedge clk) begin
        cyc <= cyc + 1;
        oe_seen <= oe_seen | oe;
        dq_seen <= dq_seen | (oe & o_dq);
        if (take) n_take <= n_take + 1;
        if (cst) n_cst <= n_cst + 1;
        if (cend) n_cend <= n_cend + 1;
        if (sdone) n_done <= n_done + 1;
        if (sblk) n_blk <= n_blk + 1;
        if (rx_v && rise) n_rise <= n_rise + 1;
        if (rx_v) n_rx <= n_rx + 1;
        if (rx_v) last_rx <= rxd;
        if (cyc == 20000) begin
            failures++;
            stop_test();
        end
    end
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            failures++;
            $display("[FAIL] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic frame(input int n, input logic wr);
        i_host.sel(1'b0);
        repeat (8) @(negedge clk);
        req = wr;
        @(negedge clk);
        req = 1'b0;
        i_host.clocks(n);
        repeat (8) @(negedge clk);
        i_host.sel(1'b1);
        repeat (8) @(negedge clk);
    endtask : frame
    task automatic t_idle();
        i_host.clocks(4);
        repeat (8) @(negedge clk);
        chk(8'(n_rx), 8'h00);
        chk(sr, 8'h00);
        chk({7'h0, standby}, 8'h01);
        chk({7'h0, act}, 8'h00);
        chk({7'h0, hold}, 8'h00);
        $display("t_idle done");
    endtask : t_idle
    task automatic t_sr();
        logic [7:0] wv [3] = '{8'h80, 8'h00, 8'h00};
        logic [3:0] wp [3] = '{4'hf, 4'hb, 4'hf};
        logic [7:0] ex [3] = '{8'h80, 8'h80, 8'h00};
        n_cst = 0;
        n_cend = 0;
        n_done = 0;
        n_blk = 0;
        for (int i = 0; i < 3; i++) begin
            wdata = wv[i];
            i_host.dq = wp[i];
            frame(0, 1'b1);
            chk(sr, ex[i]);
        end
        i_host.dq = 4'hf;
        chk(8'(n_cst), 8'h03);
        chk(8'(n_cend), 8'h03);
        chk(8'(n_done), 8'h02);
        chk(8'(n_blk), 8'h01);
        $display("t_sr done");
    endtask : t_sr
    task automatic t_lanes();
        for (int i = 0; i < 3; i++) begin
            lanes = 3'(1 << i);
            n_rx = 0;
            n_rise = 0;
            frame(4, 1'b0);
            chk(8'(n_rx), 8'h04);
            chk(8'(n_rise), 8'h04);
            chk({4'h0, last_rx}, (8'h01 << (1 << i)) - 8'h01);
        end
        lanes = 3'h1;
        dr = 1'b1;
        n_rx = 0;
        n_rise = 0;
        frame(4, 1'b0);
        chk(8'(n_rx), 8'h08);
        chk(8'(n_rise), 8'h04);
        dr = 1'b0;
        $display("t_lanes done");
    endtask : t_lanes
    task automatic t_tx();
        txen = 1'b1;
        oe_seen = 4'h0;
        dq_seen = 4'h0;
        n_take = 0;
        n_rx = 0;
        frame(2, 1'b0);
        chk({4'h0, oe_seen}, 8'h02);
        chk({4'h0, dq_seen}, 8'h02);
        chk(8'(n_take), 8'h02);
        chk({4'h0, oe}, 8'h00);
        txen = 1'b0;
        busy = 1'b1;
        frame(0, 1'b0);
        chk({7'h0, standby}, 8'h00);
        busy = 1'b0;
        repeat (2) @(negedge clk);
        chk({7'h0, standby}, 8'h01);
        $display("t_tx done");
    endtask : t_tx
    task automatic t_rst();
        for (int j = 0; j < 4; j++) begin
            nv = (j != 1);
            ev = (j != 3);
            proto = (j == 2) ? SFPI_PROTO_QUAD : SFPI_PROTO_EXTENDED;
            i_host.sel(1'b0);
            repeat (8) @(negedge clk);
            chk({7'h0, act}, 8'h01);
            i_host.dq = 4'h7;
            repeat (10) @(negedge clk);
            chk({7'h0, pin_rst}, 8'(j == 0));
            i_host.dq = 4'hf;
            repeat (8) @(negedge clk);
            i_host.sel(1'b1);
            repeat (8) @(negedge clk);
        end
        nv = 1'b1;
        ev = 1'b1;
        proto = SFPI_PROTO_EXTENDED;
        $display("t_rst done");
    endtask : t_rst
    initial begin
        repeat (10) @(negedge clk);
        nrst = 1'b1;
        t_idle();
        t_sr();
        t_lanes();
        t_tx();
        t_rst();
        stop_test();
    end
endmodule : tb
`default_nettype wire
